// ### hdl/rcc_map.vh
// register map, field positions and timing constants of the calendar core
// ----------------------------------------------------------------------------
// Functional notes
// - below supply threshold, refuse access, enter low power
// - rising supply with clock running: wait recovery delay
// - oscillator off at supply rise: access at once
// - updates follow format bit; host reloads on change
// - weekday advances at midnight, cycles 1..7, 1=Sunday
// - date rolls at month end, leap February
// - 12-hour mode: hours bit 7 means PM
// - time bytes always reachable, even during update
// - each second advance eight bytes, then compare alarm
// - alarm enable: interrupt when hh:mm:ss match alarm
// - alarm byte with top bits 11 matches anything
// - don't-care bytes give hourly, minutely, secondly alarms
// - all 128 bytes writable except C, D, A7, sec7
// - decimal ranges for seconds, minutes, date, month, year
// - century and date alarm visible only in bank 1
// - stray ones in time bytes may be overwritten
// - reads across an update may mismatch; flag avoids it
// - inhibit bit suppresses transfers and clears pending flag
// - pending flag precedes transfer by at least 244 us
// - divider 01X runs, 11X holds chain in reset
// - lowest divider bit selects register bank
// ----------------------------------------------------------------------------
`ifndef RCC_MAP_VH
`define RCC_MAP_VH
// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define RCC_SECONDS_COUNT 7'h00
`define RCC_SECONDS_ALARM 7'h01
`define RCC_MINUTES_COUNT 7'h02
`define RCC_MINUTES_ALARM 7'h03
`define RCC_HOURS_COUNT 7'h04
`define RCC_HOURS_ALARM 7'h05
`define RCC_WEEKDAY_COUNT 7'h06
`define RCC_DAY_OF_MONTH 7'h07
`define RCC_MONTH_COUNT 7'h08
`define RCC_YEAR_COUNT 7'h09
`define RCC_DIVIDER_RATE_CONTROL 7'h0a
`define RCC_MODE_INTERRUPT_CONTROL 7'h0b
`define RCC_INTERRUPT_FLAGS 7'h0c
`define RCC_BATTERY_VALID_STATUS 7'h0d
`define RCC_CENTURY_COUNT 7'h48
`define RCC_DATE_ALARM 7'h49
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RCC_B_INHIBIT 7
`define RCC_B_ALARM_IRQ_ENABLE 5
`define RCC_B_UPDATE_IRQ_ENABLE 4
`define RCC_B_BINARY_FORMAT_SEL 2
`define RCC_B_HOUR24_SEL 1
`define RCC_A_DIV_HI 6
`define RCC_A_DIV_MID 5
`define RCC_A_DIV_LO_BANK_SEL 4
`define RCC_DONT_CARE 2'b11
// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define RCC_CLK_HZ 20000000
`define RCC_SLOW_HZ 32768
`define RCC_PRESCALE_LAST 15'h7fff
`define RCC_PRESCALE_HALF 15'h4000
`define RCC_UIP_LEAD_US 244
`define RCC_UIP_LEAD_TICKS ((`RCC_UIP_LEAD_US * `RCC_SLOW_HZ + 999999) / 1000000)
`define RCC_REC_MS 200
`define RCC_REC_CYCLES ((`RCC_REC_MS * (`RCC_CLK_HZ / 1000)))
`define RCC_RESET_BYTE 8'h00
`endif

// ### hdl/rcc_core.v
// calendar core: counters, alarm, register file, power-fail access gate
`timescale 1ns/1ps
`default_nettype none
`include "rcc_map.vh"
module rcc_core #(
  parameter REC_CYCLES = `RCC_REC_CYCLES, // recovery delay in core clocks
  parameter LEAD_TICKS = `RCC_UIP_LEAD_TICKS // pending-flag lead in slow ticks
) (
  input wire core_clk,
  input wire reset_n,
  input wire tick_32k,
  input wire vcc_ok,
  input wire backup_ok,
  input wire bus_cs_n,
  input wire bus_as,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] ad_in,
  output reg [7:0] ad_out_q,
  output reg ad_oe_q,
  output reg irq_q,
  output reg access_ok_q,
  output reg low_power_q
);
  // --------------------------------------------------------------------------
  // power gate states
  // --------------------------------------------------------------------------
  localparam [1:0] ST_OFF = 2'b00; // supply low, bus refused
  localparam [1:0] ST_REC = 2'b01; // supply back, waiting out recovery
  localparam [1:0] ST_ON = 2'b10; // normal access
  localparam [14:0] UIP_AT = `RCC_PRESCALE_LAST - LEAD_TICKS[14:0];
  localparam [31:0] REC_LAST = REC_CYCLES - 1;

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------
  // stored byte to plain value, decimal digits when bcd is set
  function [7:0] f_bin;
    input [7:0] v;
    input bcd;
    begin
      f_bin = bcd ? ({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]}) : v;
    end
  endfunction
  // plain value back to stored format
  function [7:0] f_enc;
    input [7:0] b;
    input bcd;
    reg [7:0] t;
    reg [7:0] u;
    begin
      t = b / 8'd10;
      u = b % 8'd10;
      f_enc = bcd ? {t[3:0], u[3:0]} : b;
    end
  endfunction
  // days in a month, leap every fourth year only
  function [7:0] f_dim;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'd2: f_dim = (y[1:0] == 2'b00) ? 8'd29 : 8'd28;
        8'd4, 8'd6, 8'd9, 8'd11: f_dim = 8'd30;
        default: f_dim = 8'd31;
      endcase
    end
  endfunction
  // alarm byte match with don't-care top bits
  function f_match;
    input [7:0] al;
    input [7:0] tm;
    begin
      f_match = (al[7:6] == `RCC_DONT_CARE) || (al == tm);
    end
  endfunction

  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  reg [7:0] ram [0:127]; // general bytes; clock bytes live in flops
  reg [7:0] sec_q, sal_q, min_q, mal_q, hr_q, hal_q; // time and alarm
  reg [7:0] wd_q, dom_q, mon_q, yr_q, cen_q, dal_q; // calendar
  reg [6:0] rega_q; // divider and rate bits, pending flag kept apart
  reg [7:0] regb_q; // mode and enables
  reg af_q, uf_q; // sticky flags, cleared by reading the flag byte
  reg uip_q; // update pending
  reg [14:0] pre_q; // slow-tick prescaler
  reg [6:0] addr_q; // latched address
  reg rd_q; // read strobe delayed for edge detect
  reg [1:0] st_q;
  reg [31:0] rec_q;
  reg [7:0] rd_mux;

  // --------------------------------------------------------------------------
  // decode and control terms
  // --------------------------------------------------------------------------
  wire bank1 = rega_q[`RCC_A_DIV_LO_BANK_SEL];
  wire osc_on = rega_q[`RCC_A_DIV_MID];
  wire run = (rega_q[6:5] == 2'b01);
  wire chain_rst = (rega_q[6:5] == 2'b11);
  wire inhibit = regb_q[`RCC_B_INHIBIT];
  wire bcd = ~regb_q[`RCC_B_BINARY_FORMAT_SEL];
  wire h12 = ~regb_q[`RCC_B_HOUR24_SEL];
  wire granted = ~bus_cs_n & vcc_ok & (st_q == ST_ON);
  wire wr_go = granted & bus_wr;
  wire rd_edge = granted & bus_rd & ~rd_q;
  wire ext_hit = bank1 & ((addr_q == `RCC_CENTURY_COUNT) | (addr_q == `RCC_DATE_ALARM));
  wire at_last = (pre_q == `RCC_PRESCALE_LAST);
  // transfer only after a full lead of pending flag, never while inhibited
  wire upd = run & tick_32k & at_last & uip_q & ~inhibit;

  // --------------------------------------------------------------------------
  // one-second advance, computed in plain binary and re-encoded
  // --------------------------------------------------------------------------
  reg [7:0] n_sec, n_min, n_hr, n_wd, n_dom, n_mon, n_yr, n_cen;
  reg [7:0] s, m, h, d, mo, y, ce;
  reg pm, c;
  always @* begin
    s = f_bin({1'b0, sec_q[6:0]}, bcd);
    m = f_bin({1'b0, min_q[6:0]}, bcd);
    h = h12 ? f_bin({3'b000, hr_q[4:0]}, bcd) : f_bin({2'b00, hr_q[5:0]}, bcd);
    d = f_bin({2'b00, dom_q[5:0]}, bcd);
    mo = f_bin({3'b000, mon_q[4:0]}, bcd);
    y = f_bin(yr_q, bcd);
    ce = f_bin(cen_q, bcd);
    pm = hr_q[7];
    n_sec = sec_q;
    n_min = min_q;
    n_hr = hr_q;
    n_wd = wd_q;
    n_dom = dom_q;
    n_mon = mon_q;
    n_yr = yr_q;
    n_cen = cen_q;
    c = 1'b0;
    // seconds always re-encoded, clearing stray bits
    if (s >= 8'd59) begin
      n_sec = 8'h00;
      c = 1'b1;
    end else begin
      n_sec = f_enc(s + 8'd1, bcd);
    end
    if (c) begin
      c = 1'b0;
      if (m >= 8'd59) begin
        n_min = 8'h00;
        c = 1'b1;
      end else begin
        n_min = f_enc(m + 8'd1, bcd);
      end
    end
    if (c) begin
      c = 1'b0;
      if (h12) begin
        // 11 -> 12 flips meridian; midnight when PM flips back to AM
        if (h == 8'd11) begin
          n_hr = {~pm, 7'h00} | f_enc(8'd12, bcd);
          c = pm;
        end else if (h >= 8'd12) begin
          n_hr = {pm, 7'h00} | f_enc(8'd1, bcd);
        end else begin
          n_hr = {pm, 7'h00} | f_enc(h + 8'd1, bcd);
        end
      end else if (h >= 8'd23) begin
        n_hr = 8'h00;
        c = 1'b1;
      end else begin
        n_hr = f_enc(h + 8'd1, bcd);
      end
    end
    if (c) begin
      // midnight: weekday and date move together
      n_wd = (wd_q[2:0] >= 3'd7) ? 8'h01 : {5'h00, wd_q[2:0] + 3'd1};
      c = 1'b0;
      if (d >= f_dim(mo, y)) begin
        n_dom = 8'h01;
        c = 1'b1;
      end else begin
        n_dom = f_enc(d + 8'd1, bcd);
      end
    end
    if (c) begin
      c = 1'b0;
      if (mo >= 8'd12) begin
        n_mon = 8'h01;
        c = 1'b1;
      end else begin
        n_mon = f_enc(mo + 8'd1, bcd);
      end
    end
    if (c) begin
      c = 1'b0;
      if (y >= 8'd99) begin
        n_yr = 8'h00;
        c = 1'b1;
      end else begin
        n_yr = f_enc(y + 8'd1, bcd);
      end
    end
    if (c) begin
      n_cen = (ce >= 8'd99) ? 8'h00 : f_enc(ce + 8'd1, bcd);
    end
  end

  // alarm check against the freshly advanced bytes
  wire alarm_hit = f_match(sal_q, n_sec) & f_match(mal_q, n_min) & f_match(hal_q, n_hr);

  // --------------------------------------------------------------------------
  // read multiplexer
  // --------------------------------------------------------------------------
  always @* begin
    case (addr_q)
      `RCC_SECONDS_COUNT: rd_mux = sec_q;
      `RCC_SECONDS_ALARM: rd_mux = sal_q;
      `RCC_MINUTES_COUNT: rd_mux = min_q;
      `RCC_MINUTES_ALARM: rd_mux = mal_q;
      `RCC_HOURS_COUNT: rd_mux = hr_q;
      `RCC_HOURS_ALARM: rd_mux = hal_q;
      `RCC_WEEKDAY_COUNT: rd_mux = wd_q;
      `RCC_DAY_OF_MONTH: rd_mux = dom_q;
      `RCC_MONTH_COUNT: rd_mux = mon_q;
      `RCC_YEAR_COUNT: rd_mux = yr_q;
      `RCC_DIVIDER_RATE_CONTROL: rd_mux = {uip_q, rega_q};
      `RCC_MODE_INTERRUPT_CONTROL: rd_mux = regb_q;
      `RCC_INTERRUPT_FLAGS: rd_mux = {irq_q, 1'b0, af_q, uf_q, 4'h0};
      `RCC_BATTERY_VALID_STATUS: rd_mux = {backup_ok, 7'h00};
      default: begin
        // bank 1 shows the century counter and the date alarm; bank 0 shows plain RAM
        if (ext_hit) begin
          rd_mux = (addr_q == `RCC_CENTURY_COUNT) ? cen_q : dal_q;
        end else begin
          rd_mux = ram[addr_q];
        end
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // general RAM, no reset: contents hold across supply loss
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (wr_go && (addr_q > `RCC_BATTERY_VALID_STATUS) && !ext_hit) begin
      ram[addr_q] <= ad_in;
    end
  end

  // --------------------------------------------------------------------------
  // bus front end: address latch, read drive
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= 7'h00;
      rd_q <= 1'b0;
      ad_out_q <= `RCC_RESET_BYTE;
      ad_oe_q <= 1'b0;
    end else begin
      // address phase is taken even while gated; data phases are not
      if (bus_as && !bus_cs_n) begin
        addr_q <= ad_in[6:0];
      end
      rd_q <= bus_rd & granted;
      ad_oe_q <= bus_rd & granted;
      ad_out_q <= rd_mux;
    end
  end

  // --------------------------------------------------------------------------
  // power gate: low-power refusal and recovery wait
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_OFF;
      rec_q <= 32'h0000_0000;
      access_ok_q <= 1'b0;
      low_power_q <= 1'b1;
    end else begin
      case (st_q)
        ST_OFF: begin
          rec_q <= 32'h0000_0000;
          if (vcc_ok) begin
            // delay only with oscillator running and chain released
            st_q <= run ? ST_REC : ST_ON;
          end
        end
        ST_REC: begin
          rec_q <= rec_q + 32'h0000_0001;
          if (!vcc_ok) begin
            st_q <= ST_OFF;
          end else if (rec_q >= REC_LAST) begin
            st_q <= ST_ON;
          end
        end
        ST_ON: begin
          if (!vcc_ok) begin
            st_q <= ST_OFF;
          end
        end
        default: st_q <= ST_OFF;
      endcase
      access_ok_q <= (st_q == ST_ON) & vcc_ok;
      low_power_q <= ~vcc_ok | (st_q == ST_OFF);
    end
  end

  // --------------------------------------------------------------------------
  // prescaler and pending flag; counting goes on regardless of supply
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 15'h0000;
      uip_q <= 1'b0;
    end else begin
      if (chain_rst) begin
        // released chain makes its first update half a second later
        pre_q <= `RCC_PRESCALE_HALF;
      end else if (run && tick_32k) begin
        pre_q <= pre_q + 15'h0001;
      end
      // flag rises only at the lead point, so a late clear of the
      // inhibit bit skips that second instead of shortening the lead
      if (inhibit || !run || upd || (tick_32k && at_last)) begin
        uip_q <= 1'b0;
      end else if (tick_32k && (pre_q == UIP_AT)) begin
        uip_q <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // clock, calendar and control bytes; a host write beats the update
  // for its own byte, the rest advance together
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_q <= `RCC_RESET_BYTE;
      sal_q <= `RCC_RESET_BYTE;
      min_q <= `RCC_RESET_BYTE;
      mal_q <= `RCC_RESET_BYTE;
      hr_q <= `RCC_RESET_BYTE;
      hal_q <= `RCC_RESET_BYTE;
      wd_q <= `RCC_RESET_BYTE;
      dom_q <= `RCC_RESET_BYTE;
      mon_q <= `RCC_RESET_BYTE;
      yr_q <= `RCC_RESET_BYTE;
      cen_q <= `RCC_RESET_BYTE;
      dal_q <= `RCC_RESET_BYTE;
      rega_q <= 7'h00;
      regb_q <= `RCC_RESET_BYTE;
      af_q <= 1'b0;
      uf_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (upd) begin
        sec_q <= n_sec;
        min_q <= n_min;
        hr_q <= n_hr;
        wd_q <= n_wd;
        dom_q <= n_dom;
        mon_q <= n_mon;
        yr_q <= n_yr;
        cen_q <= n_cen;
      end
      // supply rise with oscillator off switches the oscillator on
      if (st_q == ST_OFF && vcc_ok && !osc_on) begin
        rega_q[`RCC_A_DIV_MID] <= 1'b1;
      end
      if (wr_go) begin
        case (addr_q)
          `RCC_SECONDS_COUNT: sec_q <= {1'b0, ad_in[6:0]};
          `RCC_SECONDS_ALARM: sal_q <= ad_in;
          `RCC_MINUTES_COUNT: min_q <= ad_in;
          `RCC_MINUTES_ALARM: mal_q <= ad_in;
          `RCC_HOURS_COUNT: hr_q <= ad_in;
          `RCC_HOURS_ALARM: hal_q <= ad_in;
          `RCC_WEEKDAY_COUNT: wd_q <= ad_in;
          `RCC_DAY_OF_MONTH: dom_q <= ad_in;
          `RCC_MONTH_COUNT: mon_q <= ad_in;
          `RCC_YEAR_COUNT: yr_q <= ad_in;
          `RCC_DIVIDER_RATE_CONTROL: rega_q <= ad_in[6:0];
          `RCC_MODE_INTERRUPT_CONTROL: regb_q <= ad_in;
          default: begin
            if (ext_hit && addr_q == `RCC_CENTURY_COUNT) begin
              cen_q <= ad_in;
            end else if (ext_hit) begin
              dal_q <= ad_in;
            end
          end
        endcase
      end
      // sticky flags: an event in the clearing cycle survives
      if (upd && alarm_hit) begin
        af_q <= 1'b1;
      end else if (rd_edge && addr_q == `RCC_INTERRUPT_FLAGS) begin
        af_q <= 1'b0;
      end
      if (upd) begin
        uf_q <= 1'b1;
      end else if (rd_edge && addr_q == `RCC_INTERRUPT_FLAGS) begin
        uf_q <= 1'b0;
      end
      irq_q <= (af_q & regb_q[`RCC_B_ALARM_IRQ_ENABLE]) |
               (uf_q & regb_q[`RCC_B_UPDATE_IRQ_ENABLE]);
    end
  end
endmodule // rcc_core
`default_nettype wire

// ### test/rcc_core_sva.sv
// concurrent checks on the calendar core bus and power gate
`timescale 1ns/1ps
`default_nettype none
module rcc_core_sva #(
  parameter REC_CYCLES = 20,
  parameter LEAD_TICKS = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tick_32k,
  input wire logic vcc_ok,
  input wire logic backup_ok,
  input wire logic bus_cs_n,
  input wire logic bus_as,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic [7:0] ad_in,
  input wire logic [7:0] ad_out_q,
  input wire logic ad_oe_q,
  input wire logic irq_q,
  input wire logic access_ok_q,
  input wire logic low_power_q
);
  // slack covers the two register stages around the gate
  localparam int REC_MAX = REC_CYCLES + 4;
  logic [31:0] wait_cnt_q; // cycles with supply up but access shut
  // ----------------------------------------
  // helper: length of each refused stretch
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt_q <= 32'h0;
    end else if (vcc_ok && !access_ok_q) begin
      wait_cnt_q <= wait_cnt_q + 32'h1;
    end else begin
      wait_cnt_q <= 32'h0;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd_start; // first cycle of a granted read
    $rose(bus_rd) && !bus_cs_n && access_ok_q && vcc_ok;
  endsequence
  sequence s_rd_held; // read still asserted while answered
    ad_oe_q && bus_rd && !bus_cs_n && access_ok_q && vcc_ok;
  endsequence
  property p_oe_answer;
    s_rd_start |=> ad_oe_q;
  endproperty
  property p_oe_hold;
    s_rd_held |=> ad_oe_q;
  endproperty
  property p_oe_drop;
    !bus_rd |=> !ad_oe_q;
  endproperty
  property p_oe_cs;
    bus_cs_n |=> !ad_oe_q;
  endproperty
  property p_oe_cut;
    !vcc_ok |-> ##2 !ad_oe_q;
  endproperty
  property p_acc_drop;
    !vcc_ok |=> !access_ok_q && low_power_q;
  endproperty
  property p_rec_bound;
    wait_cnt_q <= REC_MAX;
  endproperty
  property p_acc_rise;
    $rose(access_ok_q) |-> $past(vcc_ok) && !low_power_q;
  endproperty
  property p_lp_off;
    access_ok_q |-> !low_power_q;
  endproperty
  a_oe_answer: assert property (p_oe_answer) else $error("read got no answer");
  a_oe_hold: assert property (p_oe_hold) else $error("read answer dropped");
  a_oe_drop: assert property (p_oe_drop) else $error("bus driven without read");
  a_oe_cs: assert property (p_oe_cs) else $error("bus driven unselected");
  a_oe_cut: assert property (p_oe_cut) else $error("read served on low supply");
  a_acc_drop: assert property (p_acc_drop) else $error("access kept on low supply");
  a_rec_bound: assert property (p_rec_bound) else $error("recovery too long");
  a_acc_rise: assert property (p_acc_rise) else $error("access opened early");
  a_lp_off: assert property (p_lp_off) else $error("low power while open");
endmodule // rcc_core_sva
bind rcc_core rcc_core_sva #(.REC_CYCLES(REC_CYCLES), .LEAD_TICKS(LEAD_TICKS)) rcc_core_sva_i (
  .core_clk(core_clk), .reset_n(reset_n), .tick_32k(tick_32k), .vcc_ok(vcc_ok),
  .backup_ok(backup_ok), .bus_cs_n(bus_cs_n), .bus_as(bus_as), .bus_rd(bus_rd),
  .bus_wr(bus_wr), .ad_in(ad_in), .ad_out_q(ad_out_q), .ad_oe_q(ad_oe_q),
  .irq_q(irq_q), .access_ok_q(access_ok_q), .low_power_q(low_power_q));
`default_nettype wire

// ### test/rcc_host_model.sv
// host processor model on the multiplexed address/data bus
`timescale 1ns/1ps
`default_nettype none
module rcc_host_model (
  input wire logic core_clk,
  input wire logic [7:0] ad_out_q,
  input wire logic ad_oe_q,
  output logic bus_cs_n,
  output logic bus_as,
  output logic bus_rd,
  output logic bus_wr,
  output logic [7:0] ad_in
);
  // ----------------------------------------
  // idle bus at time zero
  // ----------------------------------------
  initial begin
    bus_cs_n = 1'b1;
    bus_as = 1'b0;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    ad_in = 8'h00;
  end
  // address phase then one-cycle write strobe, all on falling edges
  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    @(negedge core_clk);
    bus_cs_n = 1'b0;
    bus_as = 1'b1;
    ad_in = {1'b0, addr};
    @(negedge core_clk);
    bus_as = 1'b0;
    bus_wr = 1'b1;
    ad_in = data;
    @(negedge core_clk);
    bus_wr = 1'b0;
    bus_cs_n = 1'b1;
    ad_in = ~data; // released: never leave the old value standing
  endtask
  // read strobe held until the core drives the bus; x if it does not within 8 cycles
  task automatic rd(input logic [6:0] addr, output logic [7:0] data);
    int n;
    @(negedge core_clk);
    bus_cs_n = 1'b0;
    bus_as = 1'b1;
    ad_in = {1'b0, addr};
    @(negedge core_clk);
    bus_as = 1'b0;
    bus_rd = 1'b1;
    ad_in = ~ad_in;
    n = 0;
    while (ad_oe_q !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    data = (ad_oe_q === 1'b1) ? ad_out_q : 8'hxx;
    bus_rd = 1'b0;
    bus_cs_n = 1'b1;
  endtask
endmodule // rcc_host_model
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the calendar core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk, reset_n, tick_32k, vcc_ok, backup_ok;
  logic bus_cs_n, bus_as, bus_rd, bus_wr, ad_oe_q, irq_q, access_ok_q, low_power_q;
  logic [7:0] ad_in, ad_out_q, v;
  int n_tests, n_mismatch, cyc, n;
  // address, written value, expected readback
  logic [7:0] acc_tab [5][3] = '{'{8'h00, 8'hff, 8'h7f}, '{8'h01, 8'h55, 8'h55},
    '{8'h0c, 8'hff, 8'h00}, '{8'h0d, 8'h00, 8'h80}, '{8'h0a, 8'h7f, 8'h7f}};
  // case 0: decimal 24h non-leap end of february; case 1: binary 12h leap day
  logic [7:0] mode_tab [2] = '{8'h02, 8'h04};
  logic [7:0] init_tab [2][10] = '{
    '{8'h59, 8'h00, 8'h59, 8'h00, 8'h23, 8'h00, 8'h07, 8'h28, 8'h02, 8'h23},
    '{8'h3b, 8'hc0, 8'h3b, 8'hc0, 8'h8b, 8'hc0, 8'h01, 8'h1c, 8'h02, 8'h18}};
  logic [7:0] exp_tab [2][10] = '{
    '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h23},
    '{8'h00, 8'hc0, 8'h00, 8'hc0, 8'h0c, 8'hc0, 8'h02, 8'h1d, 8'h02, 8'h18}};
  // ----------------------------------------
  // design and host
  // ----------------------------------------
  rcc_core #(.REC_CYCLES(20), .LEAD_TICKS(8)) rcc_core_i (
    .core_clk(core_clk), .reset_n(reset_n), .tick_32k(tick_32k), .vcc_ok(vcc_ok),
    .backup_ok(backup_ok), .bus_cs_n(bus_cs_n), .bus_as(bus_as), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .ad_in(ad_in), .ad_out_q(ad_out_q), .ad_oe_q(ad_oe_q),
    .irq_q(irq_q), .access_ok_q(access_ok_q), .low_power_q(low_power_q));
  rcc_host_model rcc_host_model_i (
    .core_clk(core_clk), .ad_out_q(ad_out_q), .ad_oe_q(ad_oe_q), .bus_cs_n(bus_cs_n),
    .bus_as(bus_as), .bus_rd(bus_rd), .bus_wr(bus_wr), .ad_in(ad_in));
  // ----------------------------------------
  // clock, slow tick every second cycle, run limit
  // ----------------------------------------
  always #25 core_clk = ~core_clk;
  always @(negedge core_clk) tick_32k <= ~tick_32k;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin // two updates of about 33k cycles fit well inside
      n_mismatch++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    rcc_host_model_i.wr(a, d);
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    rcc_host_model_i.rd(a, r);
    chk(r, e);
  endtask
  // halt updates, load bytes 0 to 9 in one format, restart chain, resume
  task automatic load_case(input int c);
    wr(7'h0b, 8'h80 | mode_tab[c]);
    for (int i = 0; i < 10; i++) wr(i[6:0], init_tab[c][i]);
    wr(7'h0a, 8'h60);
    wr(7'h0a, 8'h20);
    wr(7'h0b, 8'h20 | mode_tab[c]);
  endtask
  task automatic wait_low_gate(input int cycles);
    vcc_ok = 1'b0;
    repeat (cycles) @(negedge core_clk);
    vcc_ok = 1'b1;
    n = 0;
    while (access_ok_q !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk({7'h0, access_ok_q}, 8'h01);
  endtask
  task automatic end_of_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    tick_32k = 1'b0;
    vcc_ok = 1'b1;
    backup_ok = 1'b1;
    n_tests = 0;
    n_mismatch = 0;
    cyc = 0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({7'h0, access_ok_q}, 8'h01);
    // read-only places and plain storage
    for (int i = 0; i < 5; i++) begin
      wr(acc_tab[i][0][6:0], acc_tab[i][1]);
      rc(acc_tab[i][0][6:0], acc_tab[i][2]);
    end
    // bank select: century seen only in bank 1
    wr(7'h48, 8'h20);
    wr(7'h0a, 8'h00);
    wr(7'h48, 8'h11);
    rc(7'h48, 8'h11);
    wr(7'h0a, 8'h10);
    rc(7'h48, 8'h20);
    // one update per case, alarm exact then all don't-care
    for (int c = 0; c < 2; c++) begin
      load_case(c);
      n = 0;
      while (irq_q !== 1'b1 && n < 34000) begin
        @(negedge core_clk);
        n++;
      end
      chk({7'h0, irq_q}, 8'h01);
      for (int i = 0; i < 10; i++) rc(i[6:0], exp_tab[c][i]);
      rc(7'h0c, 8'hb0);
      rc(7'h0c, 8'h00);
      @(negedge core_clk);
      chk({7'h0, irq_q}, 8'h00);
    end
    // supply loss with chain running: refused write, then recovery wait
    vcc_ok = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({6'h0, access_ok_q, low_power_q}, 8'h01);
    wr(7'h01, 8'h77);
    wait_low_gate(0);
    chk(8'(n >= 20), 8'h01);
    rc(7'h01, 8'hc0);
    // oscillator off: immediate access and enable bit set
    wr(7'h0a, 8'h00);
    wait_low_gate(3);
    chk(8'(n <= 3), 8'h01);
    rcc_host_model_i.rd(7'h0a, v);
    chk(v & 8'h7f, 8'h20);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
